// ==== core/cff_rx_filter_queue.sv ====
// receive frame filtering, six-slot receive queue and record window
// What this block does
// [RQ1] a transmitted frame with stamp request set captures the transmit stamp, otherwise not
// [RQ2] standard frames use identifier bits 28..18; extended frames use all 29 bits
// [RQ3] classic frames carry at most 8 payload bytes, FD frames up to 64
// [RQ4] FD frame with rate switch uses fast rate for payload and CRC
// [RQ5] error kind is meaningful only when storing all frames; that disables filtering
// [RQ6] error state bit sent in FD frames follows passive state; classic frames send 0
// [RQ7] host may place a software counter in the transmit handle byte
// [RQ8] host ignores payload bytes beyond the length code; they hold leftovers
// [RQ9] every stored frame keeps a 64-bit reception stamp, zero when stamping is off
// [RQ10] every stored frame keeps the cycle time at start of frame, zero for reference
// [RQ11] length code 0..8 gives 0..8 bytes; 9..15 gives 8 classic or 12..64 FD
// [RQ12] any enabled matching filter accepts; frame is queued and event flag raised
// [RQ13] rejected frames leave flags and pointers alone and never displace stored frames
// [RQ14] only error-free frames are filtered; erroneous ones go to error handling
// [RQ15] mask bit 0 compares the code bit, mask bit 1 ignores it
// [RQ16] a disabled filter accepts nothing whatever its mask and code
// [RQ17] after reset only filter 0 is enabled, with an all-ones mask
// [RQ18] sixteen independent code and mask filters
// [RQ19] filters see all header word bits except the stamp request and the error kind
// [RQ20] fill count kept; almost-full and full flags raised at their levels
// [RQ21] oldest slot shown in the window, any word order, host releases it
// [RQ22] full queue: valid new frame replaces oldest or is dropped; overrun flagged
// [RQ23] queue holds six frame slots in first-in first-out order
// [RQ24] stamps follow the payload at a word-aligned offset
// [RQ25] release write frees the slot and the window shows the next frame
// [RQ26] acceptance, pointers and flags commit in the cycle the frame becomes valid
`timescale 1ns/10ps
`default_nettype none
module cff_rx_filter_queue
	import cff_pkg::*;
(
	input  wire logic          clk_sys,      // controller clock, 20 MHz
	input  wire logic          srst,         // synchronous reset, active high
	input  wire logic [AW-1:0] reg_addr,     // register byte address
	input  wire logic [31:0]   reg_wdata,    // register write data
	input  wire logic          reg_wr,       // write strobe
	input  wire logic          reg_rd,       // read strobe
	output logic      [31:0]   reg_rdata,    // read data, cycle after the strobe
	input  wire logic          rx_sof,       // start of received frame
	input  wire cff_hdr_t      rx_hdr,       // header of the frame being received
	input  wire logic          rx_byte_we,   // payload byte strobe
	input  wire logic [5:0]    rx_byte_idx,  // payload byte index
	input  wire logic [7:0]    rx_byte,      // payload byte
	input  wire logic          rx_valid,     // frame valid at sixth end-of-frame bit
	input  wire logic          rx_err,       // frame ended in error
	input  wire logic          rx_ref_msg,   // frame is a reference message
	input  wire logic [63:0]   ts_now,       // external stamp timer
	input  wire logic [15:0]   cycle_time,   // cycle time counter
	input  wire logic          tx_sof,       // start of transmitted frame
	input  wire logic          tx_stamp_req, // transmit_stamp_request of that frame
	input  wire logic          tx_fdf,       // transmitted frame is FD
	input  wire logic          tx_brs,       // transmitted frame requests rate switch
	input  wire logic          tx_data_phase,// payload or CRC field in progress
	input  wire logic          err_passive,  // node is error passive
	output logic               tx_esi,       // error state bit to insert
	output logic               fast_rate,    // use fast data bit rate now
	output logic      [2:0]    rx_fill,      // rx_fill_state, stored frames
	output logic      [3:0]    rx_flags      // overrun, full, almost full, event
);
	cff_state_t s_r;
	cff_state_t s_nxt;

	logic [7:0]  pay_mem [PHYS][64];
	logic [63:0] hdr_mem [PHYS];
	logic [63:0] rts_mem [PHYS];
	logic [15:0] cyc_mem [PHYS];

	logic [63:0]      rx_words;
	logic [NFILT-1:0] f_hit;
	logic             accept;
	logic             commit;
	logic             store;

	function automatic logic [2:0] inc7(input logic [2:0] p);
		return (p == PHYS_MAX) ? 3'h0 : p + 3'h1;
	endfunction : inc7

	assign rx_words = cff_hdr_words(rx_hdr); // RQ2

	genvar gi;
	generate
		for (gi = 0; gi < NFILT; gi++)
		begin : g_filt
			// mask one is don't-care; stamp request and error kind never compared
			assign f_hit[gi] = s_r.f_en[gi] // RQ16
				& ~|((rx_words ^ s_r.f_code[gi]) & ~s_r.f_mask[gi] & FILT_CARE); // RQ15 RQ19
		end
	endgenerate

	// erroneous frames are queued only in store-all mode, unfiltered
	assign commit = rx_valid | (rx_err & s_r.store_all); // RQ14 RQ5
	assign accept = s_r.store_all | (|f_hit); // RQ12 RQ18 RQ5

	always_comb
	begin
		logic [2:0] cnt;
		logic [2:0] rp;
		logic       full;
		cnt = s_r.cnt;
		rp = s_r.rp;
		full = 1'b0;
		s_nxt = s_r;
		store = 1'b0;
		s_nxt.error_state_flag = tx_fdf & err_passive; // RQ6
		s_nxt.fast = tx_fdf & tx_brs & tx_data_phase; // RQ4
		if (tx_sof && tx_stamp_req)
			s_nxt.transmit_stamp = ts_now; // RQ1
		if (rx_sof)
		begin
			s_nxt.rts_cap = s_r.ts_en ? ts_now : 64'h0; // RQ9
			s_nxt.cyc_cap = cycle_time; // RQ10
		end
		if (reg_wr)
		begin
			unique case (reg_addr)
				A_CTRL:
				begin
					s_nxt.store_all = reg_wdata[C_ALL];
					s_nxt.ovf_drop = reg_wdata[C_DROP];
					s_nxt.ts_en = reg_wdata[C_STAMP_ENABLE];
					s_nxt.ev_en = reg_wdata[C_EVE];
					s_nxt.af_en = reg_wdata[C_AFE];
					s_nxt.fu_en = reg_wdata[C_FUE];
					s_nxt.ov_en = reg_wdata[C_OVE];
					s_nxt.af_lvl = reg_wdata[C_LVL +: 3];
				end
				A_STAT:
				begin
					s_nxt.ev_f = s_r.ev_f & ~reg_wdata[S_EV];
					s_nxt.af_f = s_r.af_f & ~reg_wdata[S_AF];
					s_nxt.fu_f = s_r.fu_f & ~reg_wdata[S_FU];
					s_nxt.ov_f = s_r.ov_f & ~reg_wdata[S_OV];
				end
				A_REL:
				begin
					if (reg_wdata[0] && cnt != 3'h0)
					begin
						rp = inc7(rp); // RQ25 RQ21
						cnt = cnt - 3'h1;
					end
				end
				A_FEN: s_nxt.f_en = reg_wdata[NFILT-1:0];
				A_FSEL: s_nxt.f_sel = reg_wdata[3:0];
				A_CODE0: s_nxt.f_code[s_r.f_sel][31:0] = reg_wdata;
				A_CODE1: s_nxt.f_code[s_r.f_sel][63:32] = reg_wdata;
				A_MASK0: s_nxt.f_mask[s_r.f_sel][31:0] = reg_wdata;
				A_MASK1: s_nxt.f_mask[s_r.f_sel][63:32] = reg_wdata;
				default: ;
			endcase
		end
		// a release in the same cycle frees room before the new frame lands
		if (commit && accept) // RQ26 RQ13
		begin
			full = (cnt == SLOTS3);
			if (!full)
			begin
				store = 1'b1;
				s_nxt.wp = inc7(s_r.wp); // RQ23
				cnt = cnt + 3'h1;
			end
			else if (!s_r.ovf_drop)
			begin
				// the spare slot took the frame; the oldest slot becomes the spare
				store = 1'b1;
				s_nxt.wp = inc7(s_r.wp); // RQ22
				rp = inc7(rp);
			end
			if (full && s_r.ov_en)
				s_nxt.ov_f = 1'b1; // RQ22
			if (store && s_r.ev_en)
				s_nxt.ev_f = 1'b1; // RQ12
			if (store && cnt == s_r.af_lvl && s_r.af_en)
				s_nxt.af_f = 1'b1; // RQ20
			if (cnt == SLOTS3 && s_r.fu_en)
				s_nxt.fu_f = 1'b1; // RQ20
		end
		s_nxt.rp = rp;
		s_nxt.cnt = cnt; // RQ20
		s_nxt.rdata = 32'h0;
		if (reg_rd)
			s_nxt.rdata = rd_word(reg_addr);
		if (srst)
		begin
			s_nxt = '0;
			s_nxt.af_lvl = LVL_RST;
			s_nxt.f_en = FEN_RST; // RQ17
			s_nxt.f_mask[0] = '1; // RQ17
		end
	end

	// register and window read mux
	function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
		logic [31:0] w;
		logic [63:0] hw;
		logic [6:0]  len;
		logic [4:0]  nw;
		logic [4:0]  wi;
		logic [4:0]  pw;
		logic [5:0]  bi;
		w = 32'h0;
		hw = hdr_mem[s_r.rp];
		// format bit sits at record bit 49, beside the length code in the upper word
		len = cff_len(hw[49], hw[35:32]); // RQ11 RQ3
		nw = 5'(7'(len + 7'h3) >> 2);
		wi = a[6:2];
		pw = wi - HDR_WORDS;
		bi = {pw[3:0], 2'h0};
		if (a < WIN_END)
		begin
			// any word in any order; the oldest stored frame is the one shown
			if (a[AW-1:7] != '0)
				w = 32'h0;
			else if (wi == 5'h0)
				w = hw[31:0]; // RQ21
			else if (wi == 5'h1)
				w = hw[63:32];
			else if (wi < HDR_WORDS)
				w = 32'h0;
			else if (pw < nw)
				w = {pay_mem[s_r.rp][bi + 6'h3], pay_mem[s_r.rp][bi + 6'h2],
					pay_mem[s_r.rp][bi + 6'h1], pay_mem[s_r.rp][bi]};
			else if (pw == nw)
				w = rts_mem[s_r.rp][31:0]; // RQ24
			else if (pw == nw + 5'h1)
				w = rts_mem[s_r.rp][63:32]; // RQ24
			else if (pw == nw + 5'h2)
				w = {16'h0, cyc_mem[s_r.rp]}; // RQ24
		end
		else
			unique case (a)
				A_CTRL: w = {21'h0, s_r.af_lvl, 1'h0, s_r.ov_en, s_r.fu_en, s_r.af_en,
					s_r.ev_en, s_r.ts_en, s_r.ovf_drop, s_r.store_all};
				A_STAT: w = {24'h0, s_r.ov_f, s_r.fu_f, s_r.af_f, s_r.ev_f, 1'h0, s_r.cnt};
				A_FEN: w = {16'h0, s_r.f_en};
				A_FSEL: w = {28'h0, s_r.f_sel};
				A_CODE0: w = s_r.f_code[s_r.f_sel][31:0];
				A_CODE1: w = s_r.f_code[s_r.f_sel][63:32];
				A_MASK0: w = s_r.f_mask[s_r.f_sel][31:0];
				A_MASK1: w = s_r.f_mask[s_r.f_sel][63:32];
				A_TTS_LO: w = s_r.transmit_stamp[31:0];
				A_TTS_HI: w = s_r.transmit_stamp[63:32];
				default: w = 32'h0;
			endcase
		return w;
	endfunction : rd_word

	always_ff @(posedge clk_sys)
		s_r <= s_nxt;

	// incoming bytes land in the slot at the write pointer, which is never a stored
	// frame, so a rejected or dropped frame is simply overwritten by the next one
	always_ff @(posedge clk_sys)
	begin
		if (rx_byte_we && (rx_hdr.fdf || rx_byte_idx < 6'h08)) // RQ3
			pay_mem[s_r.wp][rx_byte_idx] <= rx_byte;
		if (store)
		begin
			hdr_mem[s_r.wp] <= rx_words;
			rts_mem[s_r.wp] <= s_r.rts_cap; // RQ9
			cyc_mem[s_r.wp] <= rx_ref_msg ? 16'h0 : s_r.cyc_cap; // RQ10
		end
	end

	assign reg_rdata = s_r.rdata;
	assign tx_esi = s_r.error_state_flag;
	assign fast_rate = s_r.fast;
	assign rx_fill = s_r.cnt;
	assign rx_flags = {s_r.ov_f, s_r.fu_f, s_r.af_f, s_r.ev_f};
endmodule : cff_rx_filter_queue
`default_nettype wire

// ==== include/cff_pkg.sv ====
// shared constants, types and helpers of the receive frame filter and queue
package cff_pkg;
	localparam int SLOTS = 6;
	localparam int PHYS  = 7;
	localparam int NFILT = 16;
	localparam int AW    = 10;
	localparam logic [2:0] SLOTS3 = 3'h6;
	localparam logic [2:0] PHYS_MAX = 3'h6;
	// register byte addresses; the frame window sits below WIN_END
	localparam logic [AW-1:0] WIN_END   = 10'h100;
	localparam logic [AW-1:0] A_CTRL    = 10'h100;
	localparam logic [AW-1:0] A_STAT    = 10'h104;
	localparam logic [AW-1:0] A_REL     = 10'h108;
	localparam logic [AW-1:0] A_FEN     = 10'h10C;
	localparam logic [AW-1:0] A_FSEL    = 10'h110;
	localparam logic [AW-1:0] A_CODE0   = 10'h114;
	localparam logic [AW-1:0] A_CODE1   = 10'h118;
	localparam logic [AW-1:0] A_MASK0   = 10'h11C;
	localparam logic [AW-1:0] A_MASK1   = 10'h120;
	localparam logic [AW-1:0] A_TTS_LO  = 10'h124;
	localparam logic [AW-1:0] A_TTS_HI  = 10'h128;
	// control word fields
	localparam int C_ALL = 0;
	localparam int C_DROP = 1;
	localparam int C_STAMP_ENABLE = 2;
	localparam int C_EVE = 3;
	localparam int C_AFE = 4;
	localparam int C_FUE = 5;
	localparam int C_OVE = 6;
	localparam int C_LVL = 8;
	// status word fields; flags clear by writing one
	localparam int S_CNT = 0;
	localparam int S_EV = 4;
	localparam int S_AF = 5;
	localparam int S_FU = 6;
	localparam int S_OV = 7;
	localparam logic [2:0] LVL_RST = 3'h5;
	localparam logic [NFILT-1:0] FEN_RST = 16'h0001;
	// header bits that take part in filtering: no stamp request, no error kind
	localparam logic [63:0] FILT_CARE = 64'hF8FF_FFFF_7FFF_FFFF;
	localparam logic [4:0] HDR_WORDS = 5'h04;

	typedef struct packed {
		logic [28:0] id;
		logic        extended_id_flag;
		logic        fdf;
		logic        rate_switch_flag;
		logic        rmf;
		logic        error_state_flag;
		logic        lbf;
		logic [2:0]  error_kind;
		logic [3:0]  length_code;
	} cff_hdr_t;

	typedef struct packed {
		logic                  store_all;
		logic                  ovf_drop;
		logic                  ts_en;
		logic                  ev_en;
		logic                  af_en;
		logic                  fu_en;
		logic                  ov_en;
		logic [2:0]            af_lvl;
		logic                  ev_f;
		logic                  af_f;
		logic                  fu_f;
		logic                  ov_f;
		logic [2:0]            rp;
		logic [2:0]            wp;
		logic [2:0]            cnt;
		logic [NFILT-1:0]      f_en;
		logic [3:0]            f_sel;
		logic [NFILT-1:0][63:0] f_code;
		logic [NFILT-1:0][63:0] f_mask;
		logic [63:0]           rts_cap;
		logic [15:0]           cyc_cap;
		logic [63:0]           transmit_stamp;
		logic                  error_state_flag;
		logic                  fast;
		logic [31:0]           rdata;
	} cff_state_t;

	// payload bytes for a length code
	function automatic logic [6:0] cff_len(input logic fdf, input logic [3:0] length_code);
		logic [6:0] n;
		n = {3'h0, length_code};
		if (length_code > 4'h8)
		begin
			if (!fdf)
				n = 7'h08;
			else
				unique case (length_code)
					4'h9: n = 7'h0C;
					4'hA: n = 7'h10;
					4'hB: n = 7'h14;
					4'hC: n = 7'h18;
					4'hD: n = 7'h20;
					4'hE: n = 7'h30;
					default: n = 7'h40;
				endcase
		end
		return n;
	endfunction : cff_len

	// two header words in record layout, standard frames keep id(28:18) only
	function automatic logic [63:0] cff_hdr_words(input cff_hdr_t h);
		logic [28:0] id;
		id = h.extended_id_flag ? h.id : {h.id[28:18], 18'h00000};
		return {3'h0, h.lbf, h.error_state_flag, h.error_kind, 3'h0, h.rmf, 1'h0, h.rate_switch_flag, h.fdf, h.extended_id_flag,
			8'h00, 4'h0, h.length_code, 3'h0, id};
	endfunction : cff_hdr_words
endpackage : cff_pkg

// ==== sim/cff_rx_monitor.sv ====
// bound checker on the ports of the receive filter and queue
`timescale 1ns/10ps
`default_nettype none
module cff_rx_monitor
	import cff_pkg::*;
(
	input wire logic          clk_sys,       // clock
	input wire logic          srst,          // reset
	input wire logic [AW-1:0] reg_addr,      // address
	input wire logic [31:0]   reg_wdata,     // write data
	input wire logic          reg_wr,        // write strobe
	input wire logic          reg_rd,        // read strobe
	input wire logic [31:0]   reg_rdata,     // read data
	input wire logic          rx_valid,      // frame valid
	input wire logic          rx_err,        // frame error
	input wire logic          tx_fdf,        // fd transmit
	input wire logic          tx_brs,        // rate switch
	input wire logic          tx_data_phase, // data phase
	input wire logic          err_passive,   // passive node
	input wire logic          tx_esi,        // error state bit
	input wire logic          fast_rate,     // fast rate
	input wire logic [2:0]    rx_fill,       // fill count
	input wire logic [3:0]    rx_flags       // sticky flags
);
	logic all_r;
	logic ev_r;
	logic rel;
	// control bits are not visible at the ports, so shadow the writes
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			{all_r, ev_r} <= 2'h0;
		else if (reg_wr && reg_addr == A_CTRL)
			{all_r, ev_r} <= {reg_wdata[C_ALL], reg_wdata[C_EVE]};
	end
	assign rel = reg_wr && reg_addr == A_REL && reg_wdata[0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_fill_max; rx_fill <= SLOTS3; endproperty
	a_fill_max: assert property (p_fill_max) else $error("fill above six");
	property p_fill_up; rx_fill > $past(rx_fill) |-> $past(rx_valid || rx_err); endproperty
	a_fill_up: assert property (p_fill_up) else $error("fill grew without a frame end");
	property p_err_drop; rx_err && !rx_valid && !all_r && !rel |=> rx_fill == $past(rx_fill); endproperty
	a_err_drop: assert property (p_err_drop) else $error("error frame stored");
	property p_release; rel && rx_fill != 3'h0 && !rx_valid && !rx_err |=> rx_fill == $past(rx_fill) - 3'h1;
	endproperty
	a_release: assert property (p_release) else $error("release did not free a slot");
	property p_event; rx_valid && ev_r ##1 rx_fill > $past(rx_fill) |-> rx_flags[0]; endproperty
	a_event: assert property (p_event) else $error("event flag missing");
	property p_esi; !$past(srst) |-> tx_esi == $past(tx_fdf && err_passive); endproperty
	a_esi: assert property (p_esi) else $error("error state bit wrong");
	property p_fast; !$past(srst) |-> fast_rate == $past(tx_fdf && tx_brs && tx_data_phase); endproperty
	a_fast: assert property (p_fast) else $error("fast rate wrong");
endmodule : cff_rx_monitor
bind cff_rx_filter_queue cff_rx_monitor u_mon (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
	.rx_err(rx_err), .tx_fdf(tx_fdf), .tx_brs(tx_brs), .tx_data_phase(tx_data_phase),
	.err_passive(err_passive), .tx_esi(tx_esi), .fast_rate(fast_rate), .rx_fill(rx_fill), .rx_flags(rx_flags));
`default_nettype wire

// ==== sim/cff_can_node.sv ====
// model of the other bus nodes, delivering received frames
`timescale 1ns/10ps
`default_nettype none
module cff_can_node
	import cff_pkg::*;
(
	input  wire logic       clk_sys,     // clock
	output logic            rx_sof,      // start of frame
	output var cff_hdr_t    rx_hdr,      // header
	output logic            rx_byte_we,  // byte strobe
	output logic [5:0]      rx_byte_idx, // byte index
	output logic [7:0]      rx_byte,     // byte value
	output logic            rx_valid,    // frame valid
	output logic            rx_err,      // frame error
	output logic            rx_ref_msg   // reference message
);
	initial
	begin
		{rx_sof, rx_byte_we, rx_valid, rx_err, rx_ref_msg} = 5'h00;
		rx_hdr = '0;
		rx_byte_idx = 6'h00;
		rx_byte = 8'h00;
	end
	task automatic send(input cff_hdr_t h, input int n, input logic err, input logic rf);
		@(posedge clk_sys);
		rx_sof <= 1'b1;
		rx_hdr <= h;
		rx_ref_msg <= rf;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_sys);
			rx_sof <= 1'b0;
			rx_byte_we <= 1'b1;
			rx_byte_idx <= 6'(i);
			rx_byte <= 8'(i) + h.id[7:0];
		end
		@(posedge clk_sys);
		{rx_sof, rx_byte_we} <= 2'h0;
		// a released data line must not keep showing the last byte
		rx_byte <= ~rx_byte;
		rx_valid <= !err;
		rx_err <= err;
		@(posedge clk_sys);
		{rx_valid, rx_err} <= 2'h0;
	endtask : send
endmodule : cff_can_node
`default_nettype wire

// ==== sim/cff_rx_filter_queue_tb.sv ====
// self-checking bench of the receive filter and queue
`timescale 1ns/10ps
`default_nettype none
module cff_rx_filter_queue_tb
	import cff_pkg::*;
;
	logic clk_sys, srst, reg_wr, reg_rd, tx_sof, tx_stamp_req, tx_fdf, tx_brs, tx_data_phase, err_passive;
	logic tx_esi, fast_rate, rx_sof, rx_byte_we, rx_valid, rx_err, rx_ref_msg;
	logic [AW-1:0] reg_addr;
	logic [31:0]   reg_wdata, reg_rdata;
	logic [63:0]   ts_now;
	logic [15:0]   cycle_time;
	logic [2:0]    rx_fill;
	logic [3:0]    rx_flags;
	logic [5:0]    rx_byte_idx;
	logic [7:0]    rx_byte;
	cff_hdr_t      rx_hdr, h;
	int            miscompares, samples_checked, cycles;
	int            lens [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
	cff_rx_filter_queue DUT (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_sof(rx_sof), .rx_hdr(rx_hdr),
		.rx_byte_we(rx_byte_we), .rx_byte_idx(rx_byte_idx), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.rx_err(rx_err), .rx_ref_msg(rx_ref_msg), .ts_now(ts_now), .cycle_time(cycle_time), .tx_sof(tx_sof),
		.tx_stamp_req(tx_stamp_req), .tx_fdf(tx_fdf), .tx_brs(tx_brs), .tx_data_phase(tx_data_phase),
		.err_passive(err_passive), .tx_esi(tx_esi), .fast_rate(fast_rate), .rx_fill(rx_fill), .rx_flags(rx_flags));
	cff_can_node node (.clk_sys(clk_sys), .rx_sof(rx_sof), .rx_hdr(rx_hdr), .rx_byte_we(rx_byte_we),
		.rx_byte_idx(rx_byte_idx), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_err(rx_err), .rx_ref_msg(rx_ref_msg));
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	task automatic fill_is(input logic [31:0] exp);
		#1;
		chk(32'({rx_flags, 1'b0, rx_fill}), exp);
	endtask : fill_is
	// stamp position reveals the decoded payload length
	task automatic frm(input logic fd, input logic [3:0] d, input logic rf);
		int n;
		n = lens[(fd || d < 4'h9) ? d : 4'h8];
		h = '{id: 29'h0ABCDE00 | 29'(d), extended_id_flag: fd, fdf: fd, length_code: d, default: 1'b0};
		node.send(h, n, 1'b0, rf);
		rd(10'(16 + 4 * ((n + 3) / 4)), ts_now[31:0]);
		rd(10'(24 + 4 * ((n + 3) / 4)), {16'h0000, rf ? 16'h0000 : cycle_time});
		rd(10'h000, {3'h0, fd ? h.id : {h.id[28:18], 18'h00000}});
		// only words inside the decoded length are compared; later words are leftovers
		if (d == 4'h8)
			rd(10'h010, 32'h0B0A_0908);
		wr(A_REL, 32'h0000_0001);
	endtask : frm
	initial
	begin
		{srst, reg_wr, reg_rd, tx_sof, tx_stamp_req, tx_fdf, tx_brs, tx_data_phase, err_passive} = 9'h1FF & 9'h100;
		reg_addr = 10'h000;
		reg_wdata = 32'h0000_0000;
		ts_now = 64'h1234_5678_9ABC_DEF0;
		cycle_time = 16'h0A5C;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		rd(A_CTRL, 32'h0000_0500);
		rd(A_FEN, 32'h0000_0001);
		rd(A_MASK0, 32'hFFFF_FFFF);
		rd(A_MASK1, 32'hFFFF_FFFF);
		rd(10'h200, 32'h0000_0000);
		wr(A_CTRL, 32'h0000_057C);
		for (int fd = 0; fd < 2; fd++)
			for (int d = 0; d < 16; d++)
				frm(1'(fd), 4'(d), d == 3);
		fill_is(32'h0000_0010);
		wr(A_CTRL, 32'h0000_0578);
		node.send(h, 64, 1'b0, 1'b0);
		rd(10'h050, 32'h0000_0000);
		wr(A_REL, 32'h0000_0001);
		wr(A_STAT, 32'h0000_00F0);
		wr(A_FEN, 32'h0000_0002);
		wr(A_FSEL, 32'h0000_0001);
		wr(A_CODE0, 32'h0ABC_DE00);
		wr(A_MASK0, 32'hE003_FFFF);
		wr(A_MASK1, 32'hFFFF_FFFF);
		node.send(h, 1, 1'b0, 1'b0);
		fill_is(32'h0000_0011);
		h.id = h.id ^ 29'h1000_0000;
		node.send(h, 1, 1'b0, 1'b0);
		fill_is(32'h0000_0011);
		h.id = h.id ^ 29'h1000_0000;
		wr(A_FEN, 32'h0000_0000);
		node.send(h, 1, 1'b0, 1'b0);
		fill_is(32'h0000_0011);
		wr(A_FEN, 32'h0000_0002);
		node.send(h, 1, 1'b1, 1'b0);
		fill_is(32'h0000_0011);
		wr(A_CTRL, 32'h0000_0579);
		h.id = h.id ^ 29'h1000_0000;
		node.send(h, 1, 1'b1, 1'b0);
		fill_is(32'h0000_0012);
		wr(A_FEN, 32'h0000_0001);
		for (int p = 0; p < 2; p++)
		begin
			repeat (2) wr(A_REL, 32'h0000_0001);
			wr(A_CTRL, 32'h0000_0578 | 32'(p << 1));
			wr(A_STAT, 32'h0000_00F0);
			for (int k = 1; k < 8; k++)
			begin
				h = '{id: 29'(k) << 18, default: 1'b0};
				node.send(h, 0, 1'b0, 1'b0);
				if (k == 5)
					fill_is(32'h0000_0035);
			end
			fill_is(32'h0000_00F6);
			rd(10'h000, 32'(p == 1 ? 1 : 2) << 18);
			repeat (7) wr(A_REL, 32'h0000_0001);
			fill_is(32'h0000_00F0);
		end
		@(posedge clk_sys);
		tx_sof <= 1'b1;
		tx_stamp_req <= 1'b1;
		@(posedge clk_sys);
		tx_sof <= 1'b0;
		ts_now <= 64'h0000_0000_0000_0000;
		rd(A_TTS_LO, 32'h9ABC_DEF0);
		// the read returns off the edge; stimulus may only move on a rising edge
		@(posedge clk_sys);
		tx_sof <= 1'b1;
		tx_stamp_req <= 1'b0;
		@(posedge clk_sys);
		tx_sof <= 1'b0;
		{tx_fdf, tx_brs, tx_data_phase, err_passive} <= 4'hF;
		rd(A_TTS_LO, 32'h9ABC_DEF0);
		chk(32'({tx_esi, fast_rate}), 32'h0000_0003);
		@(posedge clk_sys);
		tx_fdf <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'({tx_esi, fast_rate}), 32'h0000_0000);
		report_and_stop;
	end
endmodule : cff_rx_filter_queue_tb
`default_nettype wire
